// ---- design/fdfc_top.sv ----
// Fault, ramp and switching-mode control of the LED flash driver
//
// Contract
// - Bus-clock timeout resets out_on, torch config, mode and const_v; the code resets all registers, as for undervoltage.
// - Current ramps up and down softly; upward ramp pauses out of regulation.
// - Freq switching on, flash/assist, current >= 40h: PWM, PFM at startup.
// - Indicator always uses pulse skip; low current does too, except startup (PFM) and max duty (1MHz).
// - Flash/assist near max duty may use 1MHz, else returns to 4MHz.
// - Freq switching off: no fixed-frequency mode, pulse skip instead.
// - Reading the fault register clears every fault flag not set again in the same cycle.
// - Protective fault other than overtemperature forces out_on 0, mode 00, torch config 00.
// - Transmit-mask fault only sets its flag, no shutdown.
// - Overvoltage with low drain voltage stops output, sets ovp flag.
// - Overvoltage without low drain voltage raises no fault.
// - Overvoltage fault disabled in constant-voltage mode.
// - After startup, current above 20mA, short detected: stop and flag.
// - Overtemperature stops and flags; auto re-enable once cool.
// - No overtemperature auto re-enable in constant-voltage mode.
// - Flash with torch config 01 and mask high sets txmask flag.
// - Timer starts each flash; strobe flash overrun stops and flags.
// - Timer-defined flash sets timeout flag when it finishes.
// - Undervoltage holds shutdown and all registers at defaults.
// - Active mode with out_on: bus clock low too long forces shutdown.
// - First bus clock high clears the counter and releases reset.
// - Flash timeout spans 2 ms to 1280 ms via timeout field.
//
// The implementer's own choices: the APB slave port and the register offsets.
`include "fdfc_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module fdfc_top #(
  parameter int unsigned SCL_TMO_CYC = `FDFC_SCL_TMO_CYC,
  parameter int unsigned MS_CYC      = `FDFC_MS_CYC
) (
  // Clock and reset
  input  wire logic                  I_CORE_CLK,
  input  wire logic                  I_RST,
  // APB slave
  input  wire logic                  I_PSEL,
  input  wire logic                  I_PENABLE,
  input  wire logic                  I_PWRITE,
  input  wire logic [11:0]           I_PADDR,
  input  wire logic [31:0]           I_PWDATA,
  output logic      [31:0]           O_PRDATA,
  output logic                       O_PREADY,
  output logic                       O_PSLVERR,
  // Pins and analog comparators (asynchronous)
  input  wire logic                  I_SCL,
  input  wire logic                  I_STROBE,
  input  wire logic                  I_TXMASK,
  input  wire fdfc_pkg::fdfc_analog_t I_ANA,
  // Converter and sink control
  output logic                       O_DCDC_EN,
  output logic                       O_SINK_EN,
  output logic      [7:0]            O_LED_CUR,
  output fdfc_pkg::fdfc_sw_mode_t    O_SW_MODE,
  output logic                       O_SHUTDOWN
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  assign async_in = {I_SCL, I_STROBE, I_TXMASK, I_ANA};

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  fdfc_pkg::fdfc_analog_t ana;
  logic scl;
  logic strobe;
  logic txmask;
  assign ana    = sync2_r[8:0];
  assign txmask = sync2_r[9];
  assign strobe = sync2_r[10];
  assign scl    = sync2_r[11];

  // ------------------------------------------------------------
  // Internal reset: undervoltage or bus-clock timeout
  // ------------------------------------------------------------
  logic [23:0] scl_low_cnt_r;
  logic        scl_tmo_r;
  logic        soft_rst;
  fdfc_pkg::fdfc_ctrl_t ctrl_r;
  logic        active;

  assign active = ctrl_r.out_on && (ctrl_r.mode != `FDFC_MODE_OFF);

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || scl) begin
      scl_low_cnt_r <= '0;
    end else if (scl_low_cnt_r != SCL_TMO_CYC[23:0]) begin
      scl_low_cnt_r <= scl_low_cnt_r + 24'h000001;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || scl) begin
      scl_tmo_r <= 1'b0;
    end else if (active && scl_low_cnt_r == SCL_TMO_CYC[23:0]) begin
      scl_tmo_r <= 1'b1;
    end
  end

  // Undervoltage and timeout both hold everything at defaults
  assign soft_rst = I_RST || ana.uvlo || scl_tmo_r;
  assign O_SHUTDOWN = ana.uvlo || scl_tmo_r;

  // ------------------------------------------------------------
  // APB register access
  // ------------------------------------------------------------
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [7:0]  cur_r;
  logic [7:0]  tmo_r;
  fdfc_pkg::fdfc_fault_t fault_r;
  fdfc_pkg::fdfc_fault_t fault_set;
  logic        prot_fault;
  logic        ctrl_kill;
  logic        flash_done;

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `FDFC_ADDR_CTRL) || (a == `FDFC_ADDR_CONFIG) ||
                 (a == `FDFC_ADDR_FAULT) || (a == `FDFC_ADDR_STATUS);
  endfunction : addr_known

  assign addr_ok   = addr_known(I_PADDR);
  assign wr_en     = I_PSEL && I_PENABLE && I_PWRITE && addr_ok;
  assign rd_en     = I_PSEL && I_PENABLE && !I_PWRITE;
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !addr_ok;

  always_ff @(posedge I_CORE_CLK) begin
    if (soft_rst) begin
      ctrl_r <= '0;
    end else if (ctrl_kill) begin
      ctrl_r.out_on <= 1'b0;
      ctrl_r.mode   <= `FDFC_MODE_OFF;
      ctrl_r.torch  <= `FDFC_TORCH_OFF;
    end else if (wr_en && I_PADDR == `FDFC_ADDR_CTRL) begin
      ctrl_r <= I_PWDATA[`FDFC_CTRL_FREQ_SW:`FDFC_CTRL_OUT_ON];
    end else if (flash_done) begin
      ctrl_r.out_on <= 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (soft_rst) begin
      cur_r <= `FDFC_CUR_RESET;
      tmo_r <= `FDFC_TMO_RESET;
    end else if (wr_en && I_PADDR == `FDFC_ADDR_CONFIG) begin
      cur_r <= I_PWDATA[`FDFC_CFG_CUR_HI:`FDFC_CFG_CUR_LO];
      tmo_r <= I_PWDATA[`FDFC_CFG_TMO_HI:`FDFC_CFG_TMO_LO];
    end
  end

  // ------------------------------------------------------------
  // Fault detection
  // ------------------------------------------------------------
  logic [7:0]  ramp_r;
  logic        flash;
  logic        flash_over;
  logic        ot_hold_r;

  assign flash = ctrl_r.out_on && ctrl_r.mode == `FDFC_MODE_FLASH;

  always_comb begin
    fault_set = '0;
    fault_set.ovp = O_DCDC_EN && ana.vout_max && ana.low_vds
                    && !ctrl_r.const_v;
    fault_set.short_led = O_DCDC_EN && !ana.startup && ana.led_short
                    && ramp_r > `FDFC_CUR_SHORT_MIN;
    fault_set.overtemp = ana.over_temp;
    fault_set.txmask = flash && txmask
                    && ctrl_r.torch == `FDFC_TORCH_TXMASK;
    fault_set.timeout = flash_over || flash_done;
  end

  // Transmit-mask is left out: it only flags
  assign prot_fault = fault_set.ovp || fault_set.short_led ||
                      fault_set.overtemp || flash_over;

  // Overtemperature only holds the converter, so it can restart by itself
  assign ctrl_kill = fault_set.ovp || fault_set.short_led ||
                     flash_over;

  // Set wins over a clearing read in the same cycle
  always_ff @(posedge I_CORE_CLK) begin
    if (soft_rst) begin
      fault_r <= '0;
    end else if (rd_en && I_PADDR == `FDFC_ADDR_FAULT) begin
      fault_r <= fault_set;
    end else begin
      fault_r <= fault_r | fault_set;
    end
  end

  // Converter stays off until cool; const-v mode waits for software
  always_ff @(posedge I_CORE_CLK) begin
    if (soft_rst) begin
      ot_hold_r <= 1'b0;
    end else if (ana.over_temp) begin
      ot_hold_r <= 1'b1;
    end else if (ana.temp_ok && !ctrl_r.const_v) begin
      ot_hold_r <= 1'b0;
    end else if (wr_en && I_PADDR == `FDFC_ADDR_CTRL) begin
      ot_hold_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Flash timeout timer: (field+1) * 5 ms, field 0 gives 2 ms
  // ------------------------------------------------------------
  logic [15:0] ms_cnt_r;
  logic [10:0] fl_ms_r;
  logic [10:0] fl_lim;
  logic        strobe_d_r;
  logic        fl_run_r;
  logic        strobe_flash;

  assign fl_lim = (tmo_r == 8'h00) ? 11'(`FDFC_FLASH_MIN_MS)
                : 11'((32'(tmo_r) + 32'h1) * `FDFC_FLASH_STEP_MS);
  assign strobe_flash = ctrl_r.strobe_on && ctrl_r.strobe_type;

  always_ff @(posedge I_CORE_CLK) begin
    if (soft_rst) begin
      strobe_d_r <= 1'b0;
    end else begin
      strobe_d_r <= strobe;
    end
  end

  // Timer-defined flash waits for strobe rise only with strobe use on
  always_ff @(posedge I_CORE_CLK) begin
    if (soft_rst || !flash) begin
      fl_run_r <= 1'b0;
    end else if (!ctrl_r.strobe_on || (strobe && !strobe_d_r)) begin
      fl_run_r <= 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (soft_rst || !fl_run_r) begin
      ms_cnt_r <= '0;
      fl_ms_r  <= '0;
    end else if (ms_cnt_r == 16'(MS_CYC - 1)) begin
      ms_cnt_r <= '0;
      fl_ms_r  <= fl_ms_r + 11'h001;
    end else begin
      ms_cnt_r <= ms_cnt_r + 16'h0001;
    end
  end

  assign flash_over = fl_run_r && strobe_flash && strobe
                      && fl_ms_r >= fl_lim;
  assign flash_done = fl_run_r && !strobe_flash
                      && fl_ms_r >= fl_lim;

  // ------------------------------------------------------------
  // Soft ramp of the LED current
  // ------------------------------------------------------------
  logic [15:0] ramp_div_r;
  logic [7:0]  target;
  logic        run;

  assign run    = active && !ot_hold_r &&
                  (!ctrl_r.strobe_on || !strobe_flash || strobe) &&
                  (ctrl_r.mode != `FDFC_MODE_FLASH || fl_run_r);
  assign target = run ? cur_r : `FDFC_CUR_RESET;

  always_ff @(posedge I_CORE_CLK) begin
    if (soft_rst || ramp_div_r == `FDFC_RAMP_STEP_CYC) begin
      ramp_div_r <= '0;
    end else begin
      ramp_div_r <= ramp_div_r + 16'h0001;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (soft_rst || prot_fault || ot_hold_r) begin
      ramp_r <= `FDFC_CUR_RESET;
    end else if (ramp_div_r == `FDFC_RAMP_STEP_CYC) begin
      if (ramp_r < target && !ana.out_of_reg) begin
        ramp_r <= ramp_r + 8'h01;
      end else if (ramp_r > target) begin
        ramp_r <= ramp_r - 8'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Switching mode policy and outputs
  // ------------------------------------------------------------
  fdfc_pkg::fdfc_sw_mode_t sw_nxt;
  fdfc_pkg::fdfc_sw_mode_t sw_r;
  logic dcdc_r;

  always_comb begin
    case (ctrl_r.mode)
      `FDFC_MODE_FLASH, `FDFC_MODE_ASSIST: begin
        if (!ctrl_r.freq_sw) begin
          sw_nxt = fdfc_pkg::FDFC_SW_SKIP;
        end else if (ana.startup) begin
          sw_nxt = fdfc_pkg::FDFC_SW_PFM;
        end else if (ana.max_duty) begin
          sw_nxt = fdfc_pkg::FDFC_SW_PWM1;
        end else if (cur_r >= `FDFC_CUR_PWM_MIN) begin
          sw_nxt = fdfc_pkg::FDFC_SW_PWM4;
        end else begin
          sw_nxt = fdfc_pkg::FDFC_SW_SKIP;
        end
      end
      `FDFC_MODE_INDIC: sw_nxt = fdfc_pkg::FDFC_SW_SKIP;
      default:          sw_nxt = fdfc_pkg::FDFC_SW_SKIP;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (soft_rst) begin
      sw_r   <= fdfc_pkg::FDFC_SW_SKIP;
      dcdc_r <= 1'b0;
    end else begin
      sw_r   <= sw_nxt;
      dcdc_r <= (run || ramp_r != `FDFC_CUR_RESET) && !prot_fault;
    end
  end

  assign O_SW_MODE = sw_r;
  assign O_DCDC_EN = dcdc_r;
  assign O_SINK_EN = dcdc_r;
  assign O_LED_CUR = ramp_r;

  always_comb begin
    case (I_PADDR)
      `FDFC_ADDR_CTRL:   O_PRDATA = {23'h0, ctrl_r};
      `FDFC_ADDR_CONFIG: O_PRDATA = {16'h0, tmo_r, cur_r};
      `FDFC_ADDR_FAULT:  O_PRDATA = {27'h0, fault_r};
      `FDFC_ADDR_STATUS: O_PRDATA = {20'h0, ramp_r, O_SHUTDOWN, ot_hold_r,
                                     sw_r};
      default:           O_PRDATA = 32'h0;
    endcase
  end

endmodule : fdfc_top

`default_nettype wire

// ---- shared/fdfc_regs.svh ----
// Register map, field layout and timing constants of the flash fault block
`ifndef FDFC_REGS_SVH
`define FDFC_REGS_SVH

// APB byte addresses
`define FDFC_ADDR_CTRL      12'h000
`define FDFC_ADDR_CONFIG    12'h004
`define FDFC_ADDR_FAULT     12'h008
`define FDFC_ADDR_STATUS    12'h00C

// Control register fields
`define FDFC_CTRL_OUT_ON    0
`define FDFC_CTRL_MODE_LO   1
`define FDFC_CTRL_MODE_HI   2
`define FDFC_CTRL_TORCH_LO  3
`define FDFC_CTRL_TORCH_HI  4
`define FDFC_CTRL_CONST_V   5
`define FDFC_CTRL_STROBE_ON 6
`define FDFC_CTRL_STR_TYPE  7
`define FDFC_CTRL_FREQ_SW   8

// Config register fields
`define FDFC_CFG_CUR_LO     0
`define FDFC_CFG_CUR_HI     7
`define FDFC_CFG_TMO_LO     8
`define FDFC_CFG_TMO_HI     15

// Fault register fields
`define FDFC_FLT_OVP        0
`define FDFC_FLT_SHORT      1
`define FDFC_FLT_OVERTEMP   2
`define FDFC_FLT_TXMASK     3
`define FDFC_FLT_TIMEOUT    4

// Encodings and thresholds
`define FDFC_MODE_OFF       2'h0
`define FDFC_MODE_INDIC     2'h1
`define FDFC_MODE_ASSIST    2'h2
`define FDFC_MODE_FLASH     2'h3
`define FDFC_TORCH_OFF      2'h0
`define FDFC_TORCH_TXMASK   2'h1
`define FDFC_CUR_PWM_MIN    8'h40
`define FDFC_CUR_SHORT_MIN  8'h02
`define FDFC_CUR_RESET      8'h00
`define FDFC_TMO_RESET      8'h00

// Timing
`define FDFC_CLK_HZ         10000000
`define FDFC_SCL_TMO_MS     100
`define FDFC_SCL_TMO_CYC    (`FDFC_CLK_HZ / 1000 * `FDFC_SCL_TMO_MS)
`define FDFC_FLASH_STEP_MS  5
`define FDFC_FLASH_MIN_MS   2
`define FDFC_MS_CYC         (`FDFC_CLK_HZ / 1000)
`define FDFC_RAMP_STEP_CYC  16'h0010

`endif

// ---- shared/fdfc_pkg.sv ----
// Types shared by the flash fault control block
`default_nettype none
package fdfc_pkg;

  typedef struct packed {
    logic       freq_sw;
    logic       strobe_type;
    logic       strobe_on;
    logic       const_v;
    logic [1:0] torch;
    logic [1:0] mode;
    logic       out_on;
  } fdfc_ctrl_t;

  typedef struct packed {
    logic timeout;
    logic txmask;
    logic overtemp;
    logic short_led;
    logic ovp;
  } fdfc_fault_t;

  typedef struct packed {
    logic vout_max;
    logic low_vds;
    logic led_short;
    logic over_temp;
    logic temp_ok;
    logic out_of_reg;
    logic startup;
    logic max_duty;
    logic uvlo;
  } fdfc_analog_t;

  typedef enum logic [1:0] {
    FDFC_SW_SKIP,
    FDFC_SW_PWM4,
    FDFC_SW_PWM1,
    FDFC_SW_PFM
  } fdfc_sw_mode_t;

endpackage : fdfc_pkg
`default_nettype wire

// ---- sim/fdfc_host_model.sv ----
// Host side of the two-wire bus: drives only the serial clock pin
`timescale 1ns/1ns
`default_nettype none
module fdfc_host_model (
  // Control from the bench
  input  wire logic i_frame,
  input  wire logic i_hold_low,
  // Serial clock pin
  output logic      o_scl
);
  logic tog_r = 1'b1;

  // Odd start offset keeps the bus clock out of phase with the core clock
  initial begin
    #137;
    forever begin
      #400;
      tog_r = i_frame ? ~tog_r : 1'b1;
    end
  end

  // Idle level is high through the pull-up; a dead host pins it low
  assign o_scl = i_hold_low ? 1'b0 : tog_r;
endmodule : fdfc_host_model
`default_nettype wire

// ---- sim/fdfc_checker_asserts.sv ----
// Port-level assertion checker of the flash fault control block
`timescale 1ns/1ns
`default_nettype none
module fdfc_checker #(
  parameter int unsigned SCL_TMO_CYC = 50
) (
  // Clock, reset and register bus
  input wire logic                   I_CORE_CLK,
  input wire logic                   I_RST,
  input wire logic                   I_PSEL,
  input wire logic                   I_PENABLE,
  input wire logic [11:0]            I_PADDR,
  input wire logic [31:0]            O_PRDATA,
  input wire logic                   O_PREADY,
  input wire logic                   O_PSLVERR,
  // Pins and converter control
  input wire logic                   I_SCL,
  input wire fdfc_pkg::fdfc_analog_t I_ANA,
  input wire logic                   O_DCDC_EN,
  input wire logic                   O_SINK_EN,
  input wire logic [7:0]             O_LED_CUR,
  input wire logic                   O_SHUTDOWN
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  int unsigned low_cnt_r;
  logic        unmapped;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SCL) begin
      low_cnt_r <= 0;
    end else begin
      low_cnt_r <= low_cnt_r + 1;
    end
  end

  assign unmapped = (I_PADDR > 12'h00C) || (I_PADDR[1:0] != 2'h0);

  sequence s_bad_acc;
    I_PSEL && I_PENABLE && unmapped;
  endsequence
  sequence s_scl_up;
    (I_SCL && !I_ANA.uvlo) [*5];
  endsequence
  sequence s_uvlo_free;
    !I_ANA.uvlo [*4];
  endsequence

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  ready_zero_wait_a: assert property (I_PSEL && I_PENABLE |-> O_PREADY)
    else $error("access phase without ready");
  unmapped_err_a: assert property (s_bad_acc |-> O_PSLVERR && O_PRDATA == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (I_PSEL && I_PENABLE && !unmapped |-> !O_PSLVERR)
    else $error("mapped access refused");
  uvlo_shut_a: assert property (I_ANA.uvlo [*3] |-> O_SHUTDOWN)
    else $error("undervoltage without shutdown");
  shut_off_a: assert property (O_SHUTDOWN [*3] |-> !O_SINK_EN && !O_DCDC_EN)
    else $error("output active in shutdown");
  scl_wake_a: assert property (s_scl_up |-> !O_SHUTDOWN)
    else $error("shutdown kept with bus clock high");
  scl_low_min_a: assert property (
    s_uvlo_free ##0 $rose(O_SHUTDOWN) |-> low_cnt_r >= SCL_TMO_CYC)
    else $error("bus clock shutdown too early");
  ramp_step_a: assert property (
    O_LED_CUR > $past(O_LED_CUR) |-> O_LED_CUR == $past(O_LED_CUR) + 8'h01)
    else $error("current rose by more than one step");
  reg_pause_a: assert property (
    I_ANA.out_of_reg [*4] |-> !(O_LED_CUR > $past(O_LED_CUR)))
    else $error("ramp kept rising out of regulation");
endmodule : fdfc_checker

bind fdfc_top fdfc_checker #(.SCL_TMO_CYC(SCL_TMO_CYC)) fdfc_checker_i (
  .I_CORE_CLK, .I_RST, .I_PSEL, .I_PENABLE, .I_PADDR, .O_PRDATA, .O_PREADY,
  .O_PSLVERR, .I_SCL, .I_ANA, .O_DCDC_EN, .O_SINK_EN, .O_LED_CUR, .O_SHUTDOWN
);
`default_nettype wire

// ---- sim/tb_flash_driver_fault_control.sv ----
// Self-checking bench of the flash fault control block
`timescale 1ns/1ns
`default_nettype none
module tb_flash_driver_fault_control;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic                    clk    = 1'b0;
  logic                    rst    = 1'b1;
  logic                    psel   = 1'b0;
  logic                    pen    = 1'b0;
  logic                    pwr    = 1'b0;
  logic                    strobe = 1'b0;
  logic                    txm    = 1'b0;
  logic                    frame  = 1'b0;
  logic                    hold   = 1'b0;
  logic [11:0]             paddr  = 12'h000;
  logic [31:0]             pwdata = 32'h0;
  fdfc_pkg::fdfc_analog_t  ana    = 9'h010;
  logic [31:0]             prdata, q;
  logic                    qerr;
  logic                    pready, pslverr, scl, dcdc, sink, shut;
  logic [7:0]              cur;
  fdfc_pkg::fdfc_sw_mode_t swm;
  int                      n_mismatch = 0;
  int                      cmp_count  = 0;

  always #50 clk = ~clk;

  fdfc_top #(.SCL_TMO_CYC(50), .MS_CYC(4)) fdfc_top_i (
    .I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SCL(scl), .I_STROBE(strobe),
    .I_TXMASK(txm), .I_ANA(ana), .O_DCDC_EN(dcdc), .O_SINK_EN(sink),
    .O_LED_CUR(cur), .O_SW_MODE(swm), .O_SHUTDOWN(shut)
  );
  fdfc_host_model fdfc_host_model_i (
    .i_frame(frame), .i_hold_low(hold), .o_scl(scl)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Request held from setup until ready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
    q = prdata;
    qerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : xfer

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc

  function automatic logic [7:0] pick(input int k);
    case (k)
      0: return {7'h00, sink};
      1: return cur;
      2: return {6'h00, swm};
      default: return {7'h00, shut};
    endcase
  endfunction : pick

  // Bounded wait; a value that never comes shows up as a mismatch
  task automatic wait_on(input int k, input logic [7:0] e);
    for (int i = 0; i < 3000 && pick(k) !== e; i++) @(posedge clk);
    chk(pick(k), e);
    if (pick(k) !== e) report_and_stop();
  endtask : wait_on

  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a += 4) rdc(a[11:0], 32'h0);
    xfer(1'b1, 12'h010, 32'hFFFF);
    chk(qerr, 1'b1);
    rdc(12'h010, 32'h0);
    chk(qerr, 1'b1);
    xfer(1'b1, 12'h004, 32'hFF40);
    chk(qerr, 1'b0);
    xfer(1'b1, 12'h000, 32'h105);
    repeat (200) @(posedge clk);
    ana.out_of_reg <= 1'b1;
    repeat (40) @(posedge clk);
    ana.out_of_reg <= 1'b0;
    wait_on(1, 8'h40);
    wait_on(2, 8'h01);
    ana.max_duty <= 1'b1;
    wait_on(2, 8'h02);
    ana.max_duty <= 1'b0;
    wait_on(2, 8'h01);
    ana.startup <= 1'b1;
    wait_on(2, 8'h03);
    ana.startup <= 1'b0;
    xfer(1'b1, 12'h000, 32'h103);
    wait_on(2, 8'h00);
    xfer(1'b1, 12'h000, 32'h105);
    wait_on(2, 8'h01);
    xfer(1'b1, 12'h000, 32'h005);
    wait_on(2, 8'h00);
    xfer(1'b1, 12'h000, 32'h105);
    wait_on(0, 8'h01);
    ana.vout_max <= 1'b1;
    ana.low_vds <= 1'b1;
    wait_on(0, 8'h00);
    ana <= 9'h010;
    repeat (10) @(posedge clk);
    rdc(12'h000, 32'h100);
    rdc(12'h008, 32'h01);
    rdc(12'h008, 32'h00);
    xfer(1'b1, 12'h000, 32'h105);
    wait_on(0, 8'h01);
    ana.vout_max <= 1'b1;
    repeat (20) @(posedge clk);
    chk(sink, 1'b1);
    chk(dcdc, 1'b1);
    xfer(1'b1, 12'h000, 32'h125);
    ana.low_vds <= 1'b1;
    repeat (20) @(posedge clk);
    rdc(12'h008, 32'h00);
    ana <= 9'h010;
    xfer(1'b1, 12'h000, 32'h105);
    wait_on(1, 8'h40);
    ana.led_short <= 1'b1;
    wait_on(0, 8'h00);
    ana <= 9'h010;
    rdc(12'h008, 32'h02);
    xfer(1'b1, 12'h000, 32'h105);
    wait_on(1, 8'h40);
    ana <= 9'h020;
    wait_on(0, 8'h00);
    ana <= 9'h010;
    wait_on(0, 8'h01);
    rdc(12'h008, 32'h04);
    xfer(1'b1, 12'h000, 32'h125);
    wait_on(0, 8'h01);
    ana <= 9'h020;
    wait_on(0, 8'h00);
    ana <= 9'h010;
    repeat (20) @(posedge clk);
    chk(sink, 1'b0);
    rdc(12'h008, 32'h04);
    xfer(1'b1, 12'h000, 32'h00F);
    txm <= 1'b1;
    repeat (20) @(posedge clk);
    chk(sink, 1'b1);
    rdc(12'h008, 32'h08);
    txm <= 1'b0;
    xfer(1'b1, 12'h000, 32'h000);
    xfer(1'b0, 12'h008, 32'h0);
    xfer(1'b1, 12'h004, 32'h0040);
    xfer(1'b1, 12'h000, 32'h007);
    wait_on(0, 8'h01);
    wait_on(0, 8'h00);
    rdc(12'h000, 32'h006);
    rdc(12'h008, 32'h10);
    xfer(1'b1, 12'h004, 32'h0140);
    xfer(1'b1, 12'h000, 32'h0C7);
    strobe <= 1'b1;
    wait_on(0, 8'h01);
    repeat (30) @(posedge clk);
    chk(sink, 1'b1);
    wait_on(0, 8'h00);
    strobe <= 1'b0;
    rdc(12'h008, 32'h10);
    rdc(12'h000, 32'h0C0);
    xfer(1'b1, 12'h000, 32'h105);
    frame <= 1'b1;
    repeat (300) @(posedge clk);
    chk(shut, 1'b0);
    frame <= 1'b0;
    hold <= 1'b1;
    wait_on(3, 8'h01);
    hold <= 1'b0;
    wait_on(3, 8'h00);
    rdc(12'h000, 32'h0);
    xfer(1'b1, 12'h000, 32'h105);
    ana.uvlo <= 1'b1;
    wait_on(3, 8'h01);
    ana.uvlo <= 1'b0;
    wait_on(3, 8'h00);
    rdc(12'h000, 32'h0);
    rdc(12'h004, 32'h0);
    report_and_stop();
  end
endmodule : tb_flash_driver_fault_control
`default_nettype wire
